// ==== hw/adcc_pkg.sv ====
// package of register map, field positions and codes for the converter control block
package adcc_pkg;
    // ------------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_MODE_ZERO  = 8'h00;
    localparam logic [7:0] ADDR_MODE_ONE   = 8'h04;
    localparam logic [7:0] ADDR_REF_CHECK  = 8'h08;
    localparam logic [7:0] ADDR_UPPER      = 8'h0c;
    localparam logic [7:0] ADDR_LOWER      = 8'h10;
    localparam logic [7:0] ADDR_CHANNEL    = 8'h14;
    localparam logic [7:0] ADDR_REQ_FLAGS  = 8'h18;
    localparam logic [7:0] ADDR_MASK_FLAGS = 8'h1c;
    localparam logic [7:0] ADDR_RESULT     = 8'h20;
    localparam logic [7:0] ADDR_STATUS     = 8'h24;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int BIT_COMP_EN    = 0;  // mode zero
    localparam int BIT_CONV_START = 7;  // mode zero
    localparam int BIT_CONV_MODE  = 5;  // mode one
    localparam int BIT_TRIG_LO    = 6;  // mode one
    localparam int BIT_TRIG_HI    = 7;  // mode one
    localparam int BIT_RES_SEL    = 0;  // reference/check
    localparam int BIT_LIM_CHECK  = 3;  // reference/check
    localparam int BIT_NEG_REF    = 5;  // reference/check
    localparam int BIT_POS_REF_LO = 6;  // reference/check
    localparam int BIT_POS_REF_HI = 7;  // reference/check
    localparam int BIT_INT_SRC    = 7;  // channel select
    localparam int BIT_CONV_END   = 0;  // request and mask flags
    localparam int BIT_BUSY       = 0;  // status
    localparam int BIT_BAD_SET    = 1;  // status

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_MODE  = 8'h00;
    localparam logic [7:0] RST_UPPER = 8'hff;
    localparam logic [7:0] RST_LOWER = 8'h00;
    localparam logic [7:0] RST_CHAN  = 8'h00;
    localparam logic       RST_MASK  = 1'b1;

    // ------------------------------------------------------------------
    // codes
    // ------------------------------------------------------------------
    localparam logic [1:0] POS_REF_BAD   = 2'h3;
    localparam logic [5:0] CHAN_LOW_MAX  = 6'h07;
    localparam logic [5:0] CHAN_HIGH_MIN = 6'h10;
    localparam logic [5:0] CHAN_HIGH_MAX = 6'h13;
    localparam logic [5:0] CHAN_TEMP     = 6'h20;
    localparam logic [5:0] CHAN_INT_REF  = 6'h21;
    localparam logic [1:0] AXI_OKAY      = 2'h0;
    localparam logic [1:0] AXI_SLVERR    = 2'h2;

    typedef enum logic [1:0] {
        ADCC_IDLE,
        ADCC_REQ,
        ADCC_WAIT
    } adcc_state_e;
endpackage

// ==== hw/adcc_top.sv ====
// converter control block: axi4-lite registers, conversion sequencing, window check, interrupt
//
// Decided for this implementation: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
module adcc_top #(
    parameter int ADDR_W = 8,
    parameter int RES_W  = 10
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              hw_trigger,
    input  wire logic              sample_done,
    input  wire logic [RES_W-1:0]  sample_data,
    output logic                   comparator_enable,
    output logic                   sample_request,
    output logic                   neg_ref_select,
    output logic [1:0]             pos_ref_select,
    output logic [5:0]             input_channel_select,
    output logic                   resolution_select,
    output logic                   conv_end_interrupt
);
    import adcc_pkg::*;

    // elaboration checks refuse widths the logic cannot serve
    if (ADDR_W < 8) begin : g_bad_addr
        $error("adcc_top: ADDR_W must be at least 8");
    end
    if (RES_W != 10) begin : g_bad_res
        $error("adcc_top: RES_W must be 10");
    end

    // ------------------------------------------------------------------
    // register state
    // ------------------------------------------------------------------
    logic [7:0]        mode_zero_ff, mode_one_ff, ref_check_ff, upper_ff, lower_ff, chan_ff;
    logic              req_flag_ff, mask_ff, w_strb_ff, req_ff, irq_ff;
    logic [RES_W-1:0]  result_ff;
    adcc_state_e       state_ff;
    logic              awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
    logic [1:0]        bresp_ff, rresp_ff;
    logic [31:0]       rdata_ff;
    logic [7:0]        aw_addr_ff, ar_addr_q, w_data_ff;

    // ------------------------------------------------------------------
    // write channel handshake
    // ------------------------------------------------------------------
    logic aw_take, w_take, wr_fire, wr_en, ar_take, map_hit_w, map_hit_r;
    logic bad_setting, one_shot_end, flag_clr;
    assign aw_take = s_axi_awvalid & awready_ff;
    assign w_take  = s_axi_wvalid & wready_ff;
    // both halves held and no response pending: do the write this cycle
    assign wr_fire = ~awready_ff & ~wready_ff & ~bvalid_ff;
    assign wr_en   = wr_fire & w_strb_ff & map_hit_w;
    assign ar_take = s_axi_arvalid & arready_ff;

    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a[1:0] == 2'h0) && (a <= ADDR_STATUS);
    endfunction
    assign map_hit_w = is_mapped(aw_addr_ff);
    assign map_hit_r = is_mapped(ar_addr_q);
    // address and data are accepted in either order and held until the response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_ff <= 1'b1;
            wready_ff  <= 1'b1;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= AXI_OKAY;
            aw_addr_ff <= 8'h00;
            w_data_ff  <= 8'h00;
            w_strb_ff  <= 1'b0;
        end else begin
            if (aw_take) begin
                awready_ff <= 1'b0;
                aw_addr_ff <= s_axi_awaddr[7:0];
            end
            if (w_take) begin
                wready_ff <= 1'b0;
                w_data_ff <= s_axi_wdata[7:0];
                w_strb_ff <= s_axi_wstrb[0];
            end
            if (wr_fire) begin
                bvalid_ff <= 1'b1;
                bresp_ff  <= map_hit_w ? AXI_OKAY : AXI_SLVERR;
            end
            if (bvalid_ff && s_axi_bready) begin
                bvalid_ff  <= 1'b0;
                awready_ff <= 1'b1;
                wready_ff  <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // read channel: data one cycle after the address is taken
    // ------------------------------------------------------------------
    logic [31:0] rd_mux;
    assign ar_addr_q = s_axi_araddr[7:0];

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (ar_addr_q)
            ADDR_MODE_ZERO:  rd_mux[7:0] = mode_zero_ff;
            ADDR_MODE_ONE:   rd_mux[7:0] = mode_one_ff;
            ADDR_REF_CHECK:  rd_mux[7:0] = ref_check_ff;
            ADDR_UPPER:      rd_mux[7:0] = upper_ff;
            ADDR_LOWER:      rd_mux[7:0] = lower_ff;
            ADDR_CHANNEL:    rd_mux[7:0] = chan_ff;
            ADDR_REQ_FLAGS:  rd_mux[BIT_CONV_END] = req_flag_ff;
            ADDR_MASK_FLAGS: rd_mux[BIT_CONV_END] = mask_ff;
            ADDR_RESULT:     rd_mux[RES_W-1:0] = result_ff;
            ADDR_STATUS:     rd_mux[BIT_BAD_SET:BIT_BUSY] = {bad_setting, state_ff != ADCC_IDLE};
            default:         rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_ff <= 1'b1;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= 32'h0000_0000;
            rresp_ff   <= AXI_OKAY;
        end else if (ar_take) begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b1;
            rdata_ff   <= rd_mux;
            rresp_ff   <= map_hit_r ? AXI_OKAY : AXI_SLVERR;
        end else if (rvalid_ff && s_axi_rready) begin
            rvalid_ff  <= 1'b0;
            arready_ff <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------------
    // start bit drops by itself after a one-shot conversion; a write wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_zero_ff <= RST_MODE;
        end else if (wr_en && aw_addr_ff == ADDR_MODE_ZERO) begin
            mode_zero_ff <= w_data_ff;
        end else if (one_shot_end) begin
            mode_zero_ff[BIT_CONV_START] <= 1'b0;
        end
    end
    // limits, references, channel and mode one are plain storage
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_one_ff  <= RST_MODE;
            ref_check_ff <= RST_MODE;
            upper_ff     <= RST_UPPER;
            lower_ff     <= RST_LOWER;
            chan_ff      <= RST_CHAN;
        end else if (wr_en) begin
            case (aw_addr_ff)
                ADDR_MODE_ONE:  mode_one_ff  <= w_data_ff;
                ADDR_REF_CHECK: ref_check_ff <= w_data_ff;
                ADDR_UPPER:     upper_ff     <= w_data_ff;
                ADDR_LOWER:     lower_ff     <= w_data_ff;
                ADDR_CHANNEL:   chan_ff      <= w_data_ff;
                default:        ;
            endcase
        end
    end

    // prohibited reference or channel codes hold off new conversions
    logic [5:0] chan_code;
    assign chan_code = {chan_ff[BIT_INT_SRC], chan_ff[4:0]};
    assign bad_setting = (ref_check_ff[BIT_POS_REF_HI:BIT_POS_REF_LO] == POS_REF_BAD)
                       | ~((chan_code <= CHAN_LOW_MAX)
                           | (chan_code >= CHAN_HIGH_MIN && chan_code <= CHAN_HIGH_MAX)
                           | (chan_code == CHAN_TEMP) | (chan_code == CHAN_INT_REF));

    // ------------------------------------------------------------------
    // conversion sequencer
    // ------------------------------------------------------------------
    logic run_ok, hw_mode, trig_ok, fire, in_window;
    logic [7:0] cmp_val;
    // converter runs only with the comparator on; start alone does nothing
    assign run_ok  = mode_zero_ff[BIT_COMP_EN] & mode_zero_ff[BIT_CONV_START]
                   & ~bad_setting;
    assign hw_mode = mode_one_ff[BIT_TRIG_HI];
    // no-wait and wait modes both sample on each trigger; the analog wake delay is outside
    assign trig_ok = ~hw_mode | hw_trigger;
    assign one_shot_end = (state_ff == ADCC_WAIT) & sample_done
                        & mode_one_ff[BIT_CONV_MODE] & run_ok;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff <= ADCC_IDLE;
        end else if (!run_ok) begin
            state_ff <= ADCC_IDLE;
        end else begin
            case (state_ff)
                ADCC_IDLE: state_ff <= trig_ok ? ADCC_REQ : ADCC_IDLE;
                ADCC_REQ:  state_ff <= ADCC_WAIT;
                ADCC_WAIT: state_ff <= sample_done ? ADCC_IDLE : ADCC_WAIT;
                default:   state_ff <= ADCC_IDLE;
            endcase
        end
    end

    // eight-bit mode keeps the top bits, low bits read as zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            result_ff <= '0;
        end else if (state_ff == ADCC_WAIT && sample_done && run_ok) begin
            result_ff <= ref_check_ff[BIT_RES_SEL]
                       ? {sample_data[RES_W-1:2], 2'b00} : sample_data;
        end
    end
    // limits are eight bits, so compare against the top eight result bits
    assign cmp_val   = sample_data[RES_W-1:RES_W-8];
    assign in_window = (lower_ff <= cmp_val) && (cmp_val <= upper_ff);
    assign fire = (state_ff == ADCC_WAIT) & sample_done & run_ok
                & (ref_check_ff[BIT_LIM_CHECK] ? ~in_window : in_window);

    // ------------------------------------------------------------------
    // interrupt flag and mask
    // ------------------------------------------------------------------
    assign flag_clr = wr_en & (aw_addr_ff == ADDR_REQ_FLAGS) & w_data_ff[BIT_CONV_END];

    // write one clears; a new request in the same cycle is kept
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            req_flag_ff <= 1'b0;
        end else begin
            req_flag_ff <= (req_flag_ff & ~flag_clr) | fire;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mask_ff <= RST_MASK;
        end else if (wr_en && aw_addr_ff == ADDR_MASK_FLAGS) begin
            mask_ff <= w_data_ff[BIT_CONV_END];
        end
    end
    // outputs registered so every pin comes from a flop
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_ff <= 1'b0;
            req_ff <= 1'b0;
        end else begin
            irq_ff <= req_flag_ff & ~mask_ff;
            req_ff <= (state_ff == ADCC_IDLE) & run_ok & trig_ok;
        end
    end

    // output assignments, every one straight from a flop
    assign s_axi_awready        = awready_ff;
    assign s_axi_wready         = wready_ff;
    assign s_axi_bvalid         = bvalid_ff;
    assign s_axi_bresp          = bresp_ff;
    assign s_axi_arready        = arready_ff;
    assign s_axi_rvalid         = rvalid_ff;
    assign s_axi_rdata          = rdata_ff;
    assign s_axi_rresp          = rresp_ff;
    assign comparator_enable    = mode_zero_ff[BIT_COMP_EN];
    assign sample_request       = req_ff;
    assign neg_ref_select       = ref_check_ff[BIT_NEG_REF];
    assign pos_ref_select       = ref_check_ff[BIT_POS_REF_HI:BIT_POS_REF_LO];
    assign input_channel_select = chan_code;
    assign resolution_select    = ref_check_ff[BIT_RES_SEL];
    assign conv_end_interrupt   = irq_ff;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_flag_on_fire: assert property (fire |=> req_flag_ff)
        else $error("request flag not set after a window hit");
    a_irq_masked: assert property (mask_ff && $past(mask_ff) |-> !conv_end_interrupt)
        else $error("interrupt raised while masked");
    a_irq_follows: assert property (req_flag_ff && !mask_ff |=> conv_end_interrupt)
        else $error("unmasked flag gave no interrupt");
    a_no_run_idle: assert property (!mode_zero_ff[BIT_COMP_EN] |=> state_ff == ADCC_IDLE)
        else $error("sequencer active with comparator stopped");
    a_stop_halts: assert property (!mode_zero_ff[BIT_CONV_START] |=> !sample_request)
        else $error("sample requested with start cleared");
    a_one_shot_clear: assert property (one_shot_end && !wr_en
                                       |=> !mode_zero_ff[BIT_CONV_START])
        else $error("start bit kept after one-shot conversion");
    a_window_in: assert property (fire && !ref_check_ff[BIT_LIM_CHECK]
                                  |-> cmp_val >= lower_ff && cmp_val <= upper_ff)
        else $error("inside-window request with result outside");
    a_window_out: assert property (fire && ref_check_ff[BIT_LIM_CHECK]
                                   |-> cmp_val < lower_ff || cmp_val > upper_ff)
        else $error("outside-window request with result inside");
    a_read_holds: assert property (rvalid_ff && !s_axi_rready |=> rvalid_ff && $stable(rdata_ff))
        else $error("read data dropped before the handshake");
    a_res_low_zero: assert property ($changed(result_ff)
                                     && $past(ref_check_ff[BIT_RES_SEL])
                                     |-> result_ff[1:0] == 2'b00)
        else $error("eight-bit result has low bits set");
    a_bad_ref_block: assert property (pos_ref_select == POS_REF_BAD
                                      |=> !sample_request)
        else $error("conversion ran with prohibited reference");
    a_trig_wait: assert property (hw_mode && !hw_trigger && state_ff == ADCC_IDLE
                                  |=> !sample_request)
        else $error("hardware mode sampled without trigger");
    a_resp_time: assert property (wr_fire |=> s_axi_bvalid [*1])
        else $error("write response not one cycle after both halves");
    c_window_hit:  cover property (fire ##[1:3] conv_end_interrupt);
    c_one_shot:    cover property (one_shot_end);
    c_outside_hit: cover property (fire && ref_check_ff[BIT_LIM_CHECK]);
    c_clear_race:  cover property (fire && flag_clr);
endmodule // adcc_top

// ==== verif/adcc_sar_model.sv ====
// behavioural model of the analog sampler behind the converter control block
`timescale 1ns/1ps
module adcc_sar_model (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       sample_request,
    input  wire logic [9:0] value,
    input  wire logic [3:0] delay,
    output logic            sample_done,
    output logic [9:0]      sample_data
);
    logic [3:0] cnt_ff;
    // ------------------------------------------------------------
    // conversion timing
    // ------------------------------------------------------------
    // answers delay cycles after each request, prompt or slow
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_ff      <= 4'h0;
            sample_done <= 1'b0;
        end else begin
            sample_done <= (cnt_ff == 4'h1);
            if (sample_request) begin
                cnt_ff <= delay;
            end else if (cnt_ff != 4'h0) begin
                cnt_ff <= cnt_ff - 4'h1;
            end
        end
    end
    // outside the done pulse the bus shows the inverse, so stale data never matches
    assign sample_data = sample_done ? value : ~value;
endmodule // adcc_sar_model

// ==== verif/tb_adcc_top.sv ====
// self-checking testbench of the converter control block
`timescale 1ns/1ps
module tb_adcc_top;
    import adcc_pkg::*;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, trig;
    logic        awready, wready, bvalid, arready, rvalid, done, irq, ce, req, neg, res;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [1:0]  bresp, rresp, pos, r;
    logic [5:0]  chan;
    logic [9:0]  sdata, value;
    logic [3:0]  delay;
    int          miscompares, n_tests, seed, cyc, dn, i, t, up, lo, v, hit, ch, rs, ck, mk, pr, ng;

    adcc_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .hw_trigger(trig), .sample_done(done), .sample_data(sdata), .comparator_enable(ce),
        .sample_request(req), .neg_ref_select(neg), .pos_ref_select(pos),
        .input_channel_select(chan), .resolution_select(res), .conv_end_interrupt(irq));
    adcc_sar_model sar (.aclk(aclk), .aresetn(aresetn), .sample_request(req), .value(value),
        .delay(delay), .sample_done(done), .sample_data(sdata));

    // ------------------------------------------------------------
    // bus tasks and comparison
    // ------------------------------------------------------------
    // bready and rready stay high once raised, so back-to-back calls never toggle them
    task automatic wr(input logic [7:0] a, input logic [7:0] dt, output logic [1:0] rsp);
        awaddr  <= a;
        wdata   <= {24'h0, dt};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        rsp = bresp;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] dt, output logic [1:0] rsp);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        dt = rdata;
        rsp = rresp;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // clock, watchdog and done counter
    // ------------------------------------------------------------
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    // the whole run needs about 750 cycles; a hang is cut at five thousand
    always @(posedge aclk) begin
        cyc++;
        if (done === 1'b1) dn++;
        if (cyc == 5000) begin
            miscompares++;
            end_of_test;
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, trig, awaddr, araddr, wdata} = '0;
        value = 10'h0;
        delay = 4'h1;
        seed = 2;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (i = 0; i < 8; i++) begin
            rd(i * 4, d, r);
            chk(d, (i == 3) ? 32'hff : (i == 7) ? 32'h1 : 32'h0);
        end
        wr(8'h28, 8'h55, r);
        chk({30'h0, r}, {30'h0, AXI_SLVERR});
        rd(8'h28, d, r);
        chk(d, 32'h0);
        wr(ADDR_CHANNEL, 8'h1f, r);
        wr(ADDR_MODE_ZERO, 8'h81, r);
        repeat (4) @(posedge aclk);
        rd(ADDR_STATUS, d, r);
        chk(d, 32'h2);
        wr(ADDR_MODE_ZERO, 8'h00, r);
        wr(ADDR_CHANNEL, 8'h00, r);
        wr(ADDR_REF_CHECK, 8'hc0, r);
        wr(ADDR_MODE_ZERO, 8'h81, r);
        repeat (4) @(posedge aclk);
        rd(ADDR_STATUS, d, r);
        chk(d, 32'h2);
        chk(dn, 0);
        wr(ADDR_MODE_ZERO, 8'h00, r);
        $display("test reset and refusals done");
        // random window checks, the first two right on the limits
        for (i = 0; i < 12; i++) begin
            up = $random(seed) & 255;
            lo = (i < 2) ? up / 2 : $random(seed) & 255;
            v = (i == 0) ? lo * 4 : (i == 1) ? up * 4 + 3 : $random(seed) & 1023;
            ck = (i / 2) % 2;
            mk = (i / 4) % 2;
            rs = $random(seed) & 1;
            ng = $random(seed) & 1;
            pr = i % 3;
            ch = $unsigned($random(seed)) % 14;
            ch = (ch < 8) ? ch : (ch < 12) ? ch + 8 : ch + 20;
            value <= v[9:0];
            delay <= (i % 2) ? 4'h7 : 4'h1;
            wr(ADDR_UPPER, up[7:0], r);
            wr(ADDR_LOWER, lo[7:0], r);
            wr(ADDR_REF_CHECK, {pr[1:0], ng[0], 1'b0, ck[0], 2'b00, rs[0]}, r);
            wr(ADDR_CHANNEL, {ch[5], 2'b00, ch[4:0]}, r);
            wr(ADDR_MASK_FLAGS, {7'h0, mk[0]}, r);
            wr(ADDR_MODE_ONE, (i < 8) ? 8'h20 : 8'ha0, r);
            wr(ADDR_MODE_ZERO, 8'h01, r);
            wr(ADDR_MODE_ZERO, 8'h81, r);
            // hardware trigger mode must wait for the trigger pulse
            if (i >= 8) begin
                repeat (8) @(posedge aclk);
                chk(dn, i);
                trig <= 1'b1;
                @(posedge aclk);
                trig <= 1'b0;
            end
            for (t = 0; t < 50 && dn <= i; t++) @(posedge aclk);
            repeat (3) @(posedge aclk);
            hit = ((v / 4 >= lo) && (v / 4 <= up)) ? 1 - ck : ck;
            rd(ADDR_REQ_FLAGS, d, r);
            chk(d, hit);
            chk({31'h0, irq}, hit & (1 - mk));
            rd(ADDR_RESULT, d, r);
            chk(d, rs ? (v & 1020) : v);
            rd(ADDR_MODE_ZERO, d, r);
            chk(d, 32'h01);
            chk(dn, i + 1);
            chk({22'h0, pos, neg, res, ce, chan[4:0]}, pr * 256 + ng * 128 + rs * 64 + 32 + ch % 32);
            chk({31'h0, chan[5]}, ch / 32);
            wr(ADDR_REQ_FLAGS, 8'h01, r);
            rd(ADDR_REQ_FLAGS, d, r);
            chk(d, 32'h0);
        end
        $display("test conversions done");
        // sequential mode keeps converting until start is cleared
        t = dn;
        wr(ADDR_MODE_ONE, 8'h00, r);
        wr(ADDR_MODE_ZERO, 8'h81, r);
        for (i = 0; i < 200 && dn < t + 3; i++) @(posedge aclk);
        rd(ADDR_MODE_ZERO, d, r);
        chk(d, 32'h81);
        chk(dn >= t + 3, 1);
        wr(ADDR_MODE_ZERO, 8'h01, r);
        repeat (20) @(posedge aclk);
        t = dn;
        repeat (40) @(posedge aclk);
        chk(dn, t);
        $display("test sequential done");
        end_of_test;
    end
endmodule // tb_adcc_top
